// ---- sahp_host_model.sv ----
// sahp_host_model: host side of the shared data bus, gives the wire level.
// assumes oe low means the device drives; host drives only while writing.
`timescale 1ns/1ns
module sahp_host_model (
  // bus parties
  input  wire logic        clk,
  input  wire logic        hostDrive,
  input  wire logic [15:0] hostData,
  input  wire logic        dutOe_n,
  input  wire logic [15:0] dutData,
  // resolved wire
  output      logic [15:0] busWire
);
  logic [15:0] lastReg = 16'h0000;
  always_ff @(posedge clk) lastReg <= busWire;
  // undriven bus shows the inverse of its last level
  always_comb begin
    if (!dutOe_n) busWire = dutData;
    else if (hostDrive) busWire = hostData;
    else busWire = ~lastReg;
  end
endmodule : sahp_host_model

// ---- sahp_host_port.sv ----
// sahp_host_port: conversion control and parallel host port of the converter.
// assumes pins arrive asynchronously; sampled values come from the front end on clk.
//
// Notes on behaviour
// - conversion-done output goes low once conversion of captured samples finishes.
// - conversion-done output returns high as soon as a new conversion starts.
// - a convert-start rising edge while tracking ends sampling and converts the held value; edges during conversion are ignored.
// - with sample mode bit 0, device tracks while convert-start is low.
// - power-down input high puts and keeps the device in low-current state.
// - configuration register survives entry, stay and exit of power-down.
// - low four bus lines carry configuration bits; host drives, device samples.
// - results appear on the 16-line bus, bit 15 most significant.
// - write strobe low writes; configuration loads when the strobe rises.
// - each read strobe rising edge with chip select low advances the bus to next channel.
`timescale 1ns/1ns
module sahp_host_port #(
  parameter int CHANNELS    = sahp_pkg::CHANNELS,
  parameter int DATA_W      = sahp_pkg::DATA_W,
  parameter int CONV_CYCLES = sahp_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // asynchronous pins from the host side
  input  wire sahp_pkg::sahp_pins_type           pinsIn,
  // data bus pins: input, output, output enable (low drives)
  input  wire logic [DATA_W-1:0]                 dataBusBitsIn,
  output      logic [DATA_W-1:0]                 dataBusBitsOut,
  output      logic                              dataBusOe_n,
  // captured front-end values, one per channel
  input  wire logic [CHANNELS-1:0][DATA_W-1:0]   sampleIn,
  // status outputs
  output      sahp_pkg::sahp_status_type         statusOut,
  output      logic [sahp_pkg::CFG_W-1:0]        configOut
);

  // ****************************************
  // elaboration checks
  // ****************************************
  localparam int AW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

  initial begin
    if (CHANNELS < 1 || CHANNELS > 16) begin
      $error("sahp_host_port: CHANNELS must be 1 to 16");
    end
    if (DATA_W < sahp_pkg::CFG_W) begin
      $error("sahp_host_port: DATA_W narrower than configuration field");
    end
    if (CONV_CYCLES < CHANNELS || CONV_CYCLES > 255) begin
      $error("sahp_host_port: CONV_CYCLES must be CHANNELS to 255");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sahp_pkg::sahp_pins_type           s1;
    sahp_pkg::sahp_pins_type           s2;
    sahp_pkg::sahp_pins_type           s3;
    sahp_pkg::sahp_pins_type           filt;
    sahp_pkg::sahp_phase_type          phase;
    logic [sahp_pkg::CFG_W-1:0]        cfg;
    logic [7:0]                        convCnt;
    logic [AW:0]                       wrIdx;
    logic [CHANNELS-1:0][DATA_W-1:0]   held;
    logic [AW-1:0]                     readPtr;
    logic                              eocN;
    logic                              tracking;
    logic                              lowPower;
    logic                              oe_n;
  } sahp_core_type;

  sahp_core_type r_reg;
  sahp_core_type r_next;

  logic [DATA_W-1:0] memRdData;
  logic              memWrEn;
  logic [AW-1:0]     memWrAddr;
  logic [DATA_W-1:0] memWrData;

  function automatic sahp_pkg::sahp_pins_type filterPins(input sahp_pkg::sahp_pins_type a,
                                                          input sahp_pkg::sahp_pins_type b,
                                                          input sahp_pkg::sahp_pins_type old);
    logic [$bits(sahp_pkg::sahp_pins_type)-1:0] agree;
    agree = a ~^ b;
    return sahp_pkg::sahp_pins_type'((agree & b) | (~agree & old));
  endfunction : filterPins

  function automatic logic rose(input logic oldV, input logic newV);
    return ~oldV & newV;
  endfunction : rose

  // ****************************************
  // result memory
  // ****************************************
  assign memWrEn   = (r_reg.phase == sahp_pkg::PH_CONVERT) && (r_reg.wrIdx < (AW+1)'(CHANNELS));
  assign memWrAddr = r_reg.wrIdx[AW-1:0];
  assign memWrData = r_reg.held[r_reg.wrIdx[AW-1:0]];

  sahp_result_mem #(
    .WIDTH (DATA_W),
    .DEPTH (CHANNELS),
    .AW    (AW)
  ) u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (r_reg.readPtr),
    .rdData (memRdData)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    sahp_pkg::sahp_pins_type f;
    logic                    modeBit;
    f = filterPins(r_reg.s2, r_reg.s3, r_reg.filt);
    modeBit = r_reg.cfg[sahp_pkg::CFG_MODE_POS];
    r_next = r_reg;
    r_next.s1 = pinsIn;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = f;

    // write strobe rising with select low loads the low bus lines
    if (rose(r_reg.filt.wrN, f.wrN) && !r_reg.filt.csN && !f.powerDownIn) begin
      r_next.cfg = r_reg.filt.configInputBits;
    end

    // read strobe rising advances the channel
    if (rose(r_reg.filt.rdN, f.rdN) && !r_reg.filt.csN) begin
      r_next.readPtr = (r_reg.readPtr == AW'(CHANNELS - 1)) ? '0 : r_reg.readPtr + 1'b1;
    end

    case (r_reg.phase)
      sahp_pkg::PH_TRACK: begin
        if (f.powerDownIn) begin
          r_next.phase = sahp_pkg::PH_POWERDOWN;
        end else if (rose(r_reg.filt.convertStart, f.convertStart)) begin
          r_next.phase   = sahp_pkg::PH_CONVERT;
          r_next.held    = sampleIn;
          r_next.convCnt = 8'(CONV_CYCLES - 1);
          r_next.wrIdx   = '0;
          r_next.eocN    = 1'b1;
        end
      end
      sahp_pkg::PH_CONVERT: begin
        if (f.powerDownIn) begin
          r_next.phase = sahp_pkg::PH_POWERDOWN;
        end else if (r_reg.convCnt == 8'h00) begin
          r_next.phase   = sahp_pkg::PH_TRACK;
          r_next.eocN    = 1'b0;
          r_next.readPtr = '0;
        end else begin
          r_next.convCnt = r_reg.convCnt - 8'h01;
          if (memWrEn) begin
            r_next.wrIdx = r_reg.wrIdx + 1'b1;
          end
        end
      end
      sahp_pkg::PH_POWERDOWN: begin
        // configuration is left untouched here
        if (!f.powerDownIn) begin
          r_next.phase = sahp_pkg::PH_TRACK;
        end
      end
      default: begin
        r_next.phase = sahp_pkg::PH_TRACK;
      end
    endcase

    // tracking: mode 0 only while convert-start low, mode 1 whenever idle
    r_next.tracking = (r_next.phase == sahp_pkg::PH_TRACK) && (modeBit || !f.convertStart);
    r_next.lowPower = (r_next.phase == sahp_pkg::PH_POWERDOWN);
    // drive the bus only during a selected read
    r_next.oe_n     = ~(!f.csN && !f.rdN && !f.powerDownIn);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg.s1       <= sahp_pkg::PINS_RESET;
      r_reg.s2       <= sahp_pkg::PINS_RESET;
      r_reg.s3       <= sahp_pkg::PINS_RESET;
      r_reg.filt     <= sahp_pkg::PINS_RESET;
      r_reg.phase    <= sahp_pkg::PH_TRACK;
      r_reg.cfg      <= sahp_pkg::CFG_RESET;
      r_reg.convCnt  <= 8'h00;
      r_reg.wrIdx    <= '0;
      r_reg.held     <= '0;
      r_reg.readPtr  <= '0;
      r_reg.eocN     <= 1'b1;
      r_reg.tracking <= 1'b1;
      r_reg.lowPower <= 1'b0;
      r_reg.oe_n     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // output data register, bit 15 most significant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBusBitsOut <= '0;
    end else begin
      dataBusBitsOut <= memRdData;
    end
  end

  assign dataBusOe_n        = r_reg.oe_n;
  assign statusOut          = '{eocN:     r_reg.eocN,
                                tracking: r_reg.tracking,
                                lowPower: r_reg.lowPower};
  assign configOut          = r_reg.cfg;

endmodule : sahp_host_port

// ---- sahp_host_port_checker.sv ----
// sahp_host_port_checker: timing relations at the host port pins.
// assumes bound to sahp_host_port; pins change at falling edges.
`timescale 1ns/1ns
module sahp_host_port_checker #(
  parameter int CONV_CYCLES = 30
) (
  // watched ports
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire sahp_pkg::sahp_pins_type    pinsIn,
  input wire logic                       dataBusOe_n,
  input wire sahp_pkg::sahp_status_type  statusOut,
  input wire logic [sahp_pkg::CFG_W-1:0] configOut
);
  localparam int CMIN = CONV_CYCLES - 8;
  localparam int CMAX = CONV_CYCLES - 6;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // low bus bits seen at the last write strobe rise
  logic [3:0] wrBits;
  logic       wrPrev;
  always_ff @(posedge clk) begin
    wrPrev <= pinsIn.wrN;
    if (!wrPrev && pinsIn.wrN) begin
      wrBits <= pinsIn.configInputBits;
    end
  end
  // ****
  // conversion, power-down, configuration and bus drive
  // ****
  sequence s_start;
    $rose(statusOut.eocN) && !pinsIn.powerDownIn;
  endsequence
  sequence s_busy;
    (statusOut.eocN && !statusOut.tracking)[*8];
  endsequence
  property p_done;
    s_start |-> s_busy ##[CMIN:CMAX] !statusOut.eocN;
  endproperty
  a_done: assert property (p_done) else $error("conversion end late or early");
  property p_start;
    $rose(pinsIn.convertStart) && !statusOut.eocN && !statusOut.lowPower |-> ##[3:5] statusOut.eocN;
  endproperty
  a_start: assert property (p_start) else $error("done flag not cleared on start");
  property p_track;
    !configOut[0] && !statusOut.eocN && !statusOut.lowPower && !pinsIn.convertStart && !pinsIn.powerDownIn
      |-> ##[0:5] statusOut.tracking;
  endproperty
  a_track: assert property (p_track) else $error("not tracking while start low");
  property p_pd;
    pinsIn.powerDownIn[*5] |=> statusOut.lowPower;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not entered");
  property p_nobus;
    statusOut.lowPower |-> dataBusOe_n;
  endproperty
  a_nobus: assert property (p_nobus) else $error("bus driven in power-down");
  property p_keep;
    statusOut.lowPower || $fell(statusOut.lowPower) |-> $stable(configOut);
  endproperty
  a_keep: assert property (p_keep) else $error("configuration lost in power-down");
  property p_cfg;
    $rose(pinsIn.wrN) && !pinsIn.csN && !pinsIn.powerDownIn && !statusOut.lowPower
      |-> ##[3:5] configOut == wrBits;
  endproperty
  a_cfg: assert property (p_cfg) else $error("configuration not loaded");
  property p_rdoe;
    !dataBusOe_n |-> !$past(pinsIn.csN, 4) && !$past(pinsIn.rdN, 4);
  endproperty
  a_rdoe: assert property (p_rdoe) else $error("bus driven outside a read");
endmodule : sahp_host_port_checker

// ---- sahp_pkg.sv ----
// sahp_pkg: shared constants and carrier types of the converter host port.
// assumes a single 10 MHz clock domain; all pin inputs are asynchronous.
package sahp_pkg;

  // ****************************************
  // data and configuration layout
  // ****************************************
  localparam int DATA_W        = 16;
  localparam int CHANNELS      = 8;
  localparam int CFG_W         = 4;
  localparam int CFG_MODE_POS  = 0;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS  = 3000;
  localparam int QUIET_TIME_NS = 500;
  // longest time: round down, at least one cycle
  localparam int CONV_CYCLES   = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_TIME_NS / CLK_PERIOD_NS);

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic             convertStart;
    logic             powerDownIn;
    logic             csN;
    logic             rdN;
    logic             wrN;
    logic [CFG_W-1:0] configInputBits;
  } sahp_pins_type;

  localparam sahp_pins_type PINS_RESET = '{convertStart: 1'b0, powerDownIn: 1'b0, csN: 1'b1,
                                           rdN: 1'b1, wrN: 1'b1, configInputBits: 4'h0};

  typedef struct packed {
    logic              eocN;
    logic              tracking;
    logic              lowPower;
  } sahp_status_type;

  typedef enum logic [1:0] {
    PH_TRACK,
    PH_CONVERT,
    PH_POWERDOWN
  } sahp_phase_type;

endpackage : sahp_pkg

// ---- sahp_result_mem.sv ----
// sahp_result_mem: small result store, one word per channel.
// assumes one write port and one read port on the same clock; read data registered.
`timescale 1ns/1ns
module sahp_result_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // write side
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read side
  input  wire logic [AW-1:0]    rdAddr,
  output      logic [WIDTH-1:0] rdData
);

  initial begin
    if (DEPTH < 1 || (1 << AW) < DEPTH) begin
      $error("sahp_result_mem: address width too small for depth");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end

endmodule : sahp_result_mem

// ---- tb_sahp_host_port.sv ----
// tb_sahp_host_port: directed scenarios for the converter host port.
// assumes the host model resolves the shared bus; pins move at falling edges.
`timescale 1ns/1ns
module tb_sahp_host_port;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      conv = 1'b0;
  logic                      pd = 1'b0;
  logic                      csN = 1'b1;
  logic                      rdN = 1'b1;
  logic                      wrN = 1'b1;
  logic                      hostDrive = 1'b0;
  logic [15:0]               hostData = 16'h0000;
  logic [7:0][15:0]          samples = '0;
  logic [15:0]               busOut;
  logic [15:0]               busWire;
  logic                      oeN;
  logic [3:0]                cfg;
  sahp_pkg::sahp_status_type st;
  int                        n_fail = 0;
  int                        check_count = 0;
  int                        cycles = 0;
  wire sahp_pkg::sahp_pins_type pins = {conv, pd, csN, rdN, wrN, busWire[3:0]};
  sahp_host_port dut (.clk(clk), .rst_n(rst_n), .pinsIn(pins), .dataBusBitsIn(busWire), .dataBusBitsOut(busOut),
    .dataBusOe_n(oeN), .sampleIn(samples), .statusOut(st), .configOut(cfg));
  sahp_host_model host (.clk(clk), .hostDrive(hostDrive), .hostData(hostData), .dutOe_n(oeN), .dutData(busOut),
    .busWire(busWire));
  initial forever #50 clk = ~clk;
  // ****
  // tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic t_convert(input logic [15:0] base);
    int i;
    for (i = 0; i < 8; i++) samples[i] = base + 16'(i);
    tick(6);
    conv = 1'b1;
    i = 0;
    while (st.tracking !== 1'b0 && i < 9) begin
      tick(1);
      i++;
    end
    check(16'(st.eocN), 16'h0001);
    check(16'(st.tracking), 16'h0000);
    samples = ~samples;
    i = 0;
    while (st.eocN !== 1'b0 && i < 60) begin
      conv = (i < 10 || i > 14);
      tick(1);
      i++;
    end
    check(16'(i), 16'(sahp_pkg::CONV_CYCLES));
    conv = 1'b0;
    tick(6);
    check(16'(st.tracking), 16'h0001);
  endtask : t_convert
  task automatic t_read(input logic [15:0] base, input int n);
    int i;
    rdN = 1'b0;
    tick(6);
    rdN = 1'b1;
    tick(6);
    csN = 1'b0;
    for (i = 0; i < n; i++) begin
      rdN = 1'b0;
      tick(6);
      check(busWire, base + 16'(i % 8));
      rdN = 1'b1;
      tick(6);
    end
    csN = 1'b1;
    tick(6);
  endtask : t_read
  task automatic t_write(input logic [3:0] v, input logic [3:0] exp);
    csN = 1'b0;
    wrN = 1'b0;
    hostDrive = 1'b1;
    hostData = {12'h000, v};
    tick(4);
    wrN = 1'b1;
    tick(2);
    csN = 1'b1;
    hostDrive = 1'b0;
    tick(6);
    check({12'h000, cfg}, {12'h000, exp});
  endtask : t_write
  task automatic t_powerdown;
    pd = 1'b1;
    tick(8);
    check(16'(st.lowPower), 16'h0001);
    csN = 1'b0;
    rdN = 1'b0;
    tick(6);
    check(16'(oeN), 16'h0001);
    rdN = 1'b1;
    tick(2);
    csN = 1'b1;
    tick(6);
    t_write(4'ha, 4'h5);
    pd = 1'b0;
    tick(8);
    check({12'h000, cfg}, 16'h0005);
  endtask : t_powerdown
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(2);
    check({12'h000, cfg}, 16'h0000);
    check(16'(oeN), 16'h0001);
    check(16'(st.eocN), 16'h0001);
    check(16'(st.lowPower), 16'h0000);
    t_convert(16'ha5c0);
    t_read(16'ha5c0, 9);
    t_write(4'h5, 4'h5);
    t_convert(16'h8e30);
    t_read(16'h8e30, 2);
    t_powerdown();
    t_write(4'h0, 4'h0);
    t_convert(16'hf102);
    t_read(16'hf102, 1);
    test_done();
  end
endmodule : tb_sahp_host_port
bind sahp_host_port sahp_host_port_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (.clk(clk), .rst_n(rst_n),
  .pinsIn(pinsIn), .dataBusOe_n(dataBusOe_n), .statusOut(statusOut), .configOut(configOut));
